//--- xcv_top.sv
// Top of the 18-bit bus transceiver with its test logic and APB registers.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module xcv_top
  import xcv_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [XCV_AW-1:0] paddr,
  input  wire logic [XCV_DW-1:0] pwdata,
  output logic      [XCV_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // A port
  input  wire logic [XCV_W-1:0]  a_in,
  output logic      [XCV_W-1:0]  a_out,
  output logic      [XCV_W-1:0]  a_oe_n,
  // B port
  input  wire logic [XCV_W-1:0]  b_in,
  output logic      [XCV_W-1:0]  b_out,
  output logic      [XCV_W-1:0]  b_oe_n,
  // Direction control pins
  input  wire xcv_dir_ctl_s      fwd_ctl,
  input  wire xcv_dir_ctl_s      rev_ctl,
  // Test clock and test-logic-reset level
  input  wire logic              tck,
  input  wire logic              test_logic_reset
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [CTRL_W-1:0]     ctrl_q;
  logic [XCV_W-1:0]      sample_a_q;
  logic [XCV_W-1:0]      sample_b_q;
  logic [2*XCV_CTLW-1:0] sample_ctl_q;
  logic [XCV_W-1:0]      sig_q;
  logic [XCV_W-1:0]      pattern_q;
  logic                  tck_q;
  logic [XCV_DW-1:0]     prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [XCV_W-1:0]      a_out_q;
  logic [XCV_W-1:0]      a_oe_n_q;
  logic [XCV_W-1:0]      b_out_q;
  logic [XCV_W-1:0]      b_oe_n_q;

  // ---------------------------------------------------------------------------
  // Test control decode
  // ---------------------------------------------------------------------------
  wire          tck_rise    = tck & ~tck_q;
  wire          test_active = ctrl_q[CTRL_TEST_BIT] & ~test_logic_reset;
  wire xcv_op_e op          = xcv_op_e'(ctrl_q[CTRL_OP_LSB +: 2]);
  wire          drive_a     = ctrl_q[CTRL_DRV_A_BIT];
  wire          drive_b     = ctrl_q[CTRL_DRV_B_BIT];

  // Snapshot is harmless in normal mode; compression and patterns need test mode.
  wire do_sample = tck_rise & (op == XCV_OP_SAMPLE);
  wire do_psa    = tck_rise & test_active & (op == XCV_OP_PSA);
  wire do_output_random_pattern   = tck_rise & test_active & (op == XCV_OP_OUTPUT_RANDOM_PATTERN);

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  wire access   = psel & penable;
  wire first    = access & ~pready_q;
  wire done     = access & pready_q;

  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_sa   = (paddr == OFS_SAMPLE_A);
  wire hit_sb   = (paddr == OFS_SAMPLE_B);
  wire hit_sc   = (paddr == OFS_SAMPLE_CTL);
  wire hit_sig  = (paddr == OFS_SIG);
  wire hit_pat  = (paddr == OFS_PATTERN);
  wire hit_fh   = (paddr == OFS_FWD_HELD);
  wire hit_rh   = (paddr == OFS_REV_HELD);
  wire hit_any  = hit_ctrl | hit_stat | hit_sa | hit_sb | hit_sc | hit_sig | hit_pat
                | hit_fh | hit_rh;

  wire wr_ctrl  = done & pwrite & hit_ctrl;
  wire wr_sig   = done & pwrite & hit_sig;
  wire wr_pat   = done & pwrite & hit_pat;

  // ---------------------------------------------------------------------------
  // Direction storage
  // ---------------------------------------------------------------------------
  logic [XCV_W-1:0] fwd_held;
  logic [XCV_W-1:0] rev_held;

  // Test mode freezes both directions so the functional path stays inhibited.
  xcv_dir u_fwd (
    .mclk   (mclk),
    .nrst   (nrst),
    .ctl    (fwd_ctl),
    .freeze (test_active),
    .din    (a_in),
    .held   (fwd_held)
  );

  xcv_dir u_rev (
    .mclk   (mclk),
    .nrst   (nrst),
    .ctl    (rev_ctl),
    .freeze (test_active),
    .din    (b_in),
    .held   (rev_held)
  );

  // ---------------------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------------------
  wire [XCV_DW-1:0] stat_word = {30'h0, test_logic_reset, test_active};
  wire [XCV_DW-1:0] rdata =
      hit_ctrl ? {27'h0, ctrl_q}       :
      hit_stat ? stat_word             :
      hit_sa   ? {14'h0, sample_a_q}   :
      hit_sb   ? {14'h0, sample_b_q}   :
      hit_sc   ? {20'h0, sample_ctl_q} :
      hit_sig  ? {14'h0, sig_q}        :
      hit_pat  ? {14'h0, pattern_q}    :
      hit_fh   ? {14'h0, fwd_held}     :
      hit_rh   ? {14'h0, rev_held}     :
                 32'h0;

  // ---------------------------------------------------------------------------
  // Pin drive selection
  // ---------------------------------------------------------------------------
  // Output enables per half, widened to one bit per pin.
  wire [XCV_W-1:0] fwd_oe_n = {{XCV_HALF{fwd_ctl.oe_n[1]}}, {XCV_HALF{fwd_ctl.oe_n[0]}}};
  wire [XCV_W-1:0] rev_oe_n = {{XCV_HALF{rev_ctl.oe_n[1]}}, {XCV_HALF{rev_ctl.oe_n[0]}}};

  // In test mode the pattern register drives each port whose drive bit is set, which lets a sample
  // read back the driven pattern as a boundary self-test.
  wire [XCV_W-1:0] b_out_d  = test_active ? pattern_q : fwd_held;
  wire [XCV_W-1:0] b_oe_n_d = test_active ? {XCV_W{~drive_b}} : fwd_oe_n;
  wire [XCV_W-1:0] a_out_d  = test_active ? pattern_q : rev_held;
  wire [XCV_W-1:0] a_oe_n_d = test_active ? {XCV_W{~drive_a}} : rev_oe_n;

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= first;
      pslverr_q <= first & ~hit_any;
      prdata_q  <= (first & ~pwrite & hit_any) ? rdata : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
    end else if (test_logic_reset) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Test clock edge detection
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin snapshot
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sample_a_q   <= '0;
      sample_b_q   <= '0;
      sample_ctl_q <= '0;
    end else if (test_logic_reset) begin
      sample_a_q   <= '0;
      sample_b_q   <= '0;
      sample_ctl_q <= '0;
    end else if (do_sample) begin
      sample_a_q   <= a_in;
      sample_b_q   <= b_in;
      sample_ctl_q <= {fwd_ctl, rev_ctl};
    end
  end

  // ---------------------------------------------------------------------------
  // Input signature compression
  // ---------------------------------------------------------------------------
  // A bus write in the same cycle as a test clock edge wins.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sig_q <= SIG_RST;
    end else if (test_logic_reset) begin
      sig_q <= SIG_RST;
    end else if (wr_sig) begin
      sig_q <= pwdata[XCV_W-1:0];
    end else if (do_psa) begin
      sig_q <= lfsr_step(sig_q) ^ a_in ^ b_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Output pattern generation
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pattern_q <= PATTERN_RST;
    end else if (test_logic_reset) begin
      pattern_q <= PATTERN_RST;
    end else if (wr_pat) begin
      pattern_q <= pwdata[XCV_W-1:0];
    end else if (do_output_random_pattern) begin
      pattern_q <= lfsr_step(pattern_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Pin output flip-flops
  // ---------------------------------------------------------------------------
  // All pins start released so nothing contends with the buses after reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      a_out_q  <= '0;
      a_oe_n_q <= '1;
      b_out_q  <= '0;
      b_oe_n_q <= '1;
    end else begin
      a_out_q  <= a_out_d;
      a_oe_n_q <= a_oe_n_d;
      b_out_q  <= b_out_d;
      b_oe_n_q <= b_oe_n_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign a_out   = a_out_q;
  assign a_oe_n  = a_oe_n_q;
  assign b_out   = b_out_q;
  assign b_oe_n  = b_oe_n_q;

endmodule : xcv_top

//--- xcv_pkg.sv
// Package with constants, types and helpers shared by the transceiver datapath.
package xcv_pkg;

  // ---------------------------------------------------------------------------
  // Datapath geometry
  // ---------------------------------------------------------------------------
  localparam int XCV_W     = 18;
  localparam int XCV_HALF  = 9;
  localparam int XCV_NHALF = 2;
  localparam int XCV_AW    = 8;
  localparam int XCV_DW    = 32;
  localparam int XCV_CTLW  = 6;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [XCV_AW-1:0] OFS_CTRL       = 8'h00;
  localparam logic [XCV_AW-1:0] OFS_STATUS     = 8'h04;
  localparam logic [XCV_AW-1:0] OFS_SAMPLE_A   = 8'h08;
  localparam logic [XCV_AW-1:0] OFS_SAMPLE_B   = 8'h0C;
  localparam logic [XCV_AW-1:0] OFS_SAMPLE_CTL = 8'h10;
  localparam logic [XCV_AW-1:0] OFS_SIG        = 8'h14;
  localparam logic [XCV_AW-1:0] OFS_PATTERN    = 8'h18;
  localparam logic [XCV_AW-1:0] OFS_FWD_HELD   = 8'h1C;
  localparam logic [XCV_AW-1:0] OFS_REV_HELD   = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_TEST_BIT  = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_DRV_A_BIT = 3;
  localparam int CTRL_DRV_B_BIT = 4;
  localparam int CTRL_W         = 5;
  localparam int STAT_TEST_BIT  = 0;
  localparam int STAT_TLR_BIT   = 1;

  localparam logic [CTRL_W-1:0] CTRL_RST    = 5'h00;
  localparam logic [XCV_W-1:0]  PATTERN_RST = 18'h00001;
  localparam logic [XCV_W-1:0]  SIG_RST     = 18'h00000;
  localparam logic [XCV_W-1:0]  LFSR_TAPS   = 18'h20400;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    XCV_OP_HOLD,
    XCV_OP_SAMPLE,
    XCV_OP_PSA,
    XCV_OP_OUTPUT_RANDOM_PATTERN
  } xcv_op_e;

  // Control pins of one direction, one bit per 9-bit half.
  typedef struct packed {
    logic [XCV_NHALF-1:0] oe_n;
    logic [XCV_NHALF-1:0] le;
    logic [XCV_NHALF-1:0] clk;
  } xcv_dir_ctl_s;

  // One step of the 18-bit shift register used for patterns and signatures.
  function automatic logic [XCV_W-1:0] lfsr_step(input logic [XCV_W-1:0] v);
    return {v[XCV_W-2:0], ^(v & LFSR_TAPS)};
  endfunction : lfsr_step

endpackage : xcv_pkg

//--- xcv_dir.sv
// One direction of storage: a latch-or-flop element per bit, split in halves.
`timescale 1ns/1ps
module xcv_dir
  import xcv_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Direction controls and test freeze
  input  wire xcv_dir_ctl_s     ctl,
  input  wire logic             freeze,
  // Data
  input  wire logic [XCV_W-1:0] din,
  output logic      [XCV_W-1:0] held
);

  logic [XCV_NHALF-1:0] clk_q;

  // ---------------------------------------------------------------------------
  // Per-half storage
  // ---------------------------------------------------------------------------
  for (genvar h = 0; h < XCV_NHALF; h++) begin : g_half
    wire rise = ctl.clk[h] & ~clk_q[h];
    // One element serves as latch (enable high) and as flop (enable low).
    wire load = ~freeze & (ctl.le[h] | rise);

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        clk_q[h] <= 1'b0;
      end else begin
        clk_q[h] <= ctl.clk[h];
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        held[h*XCV_HALF +: XCV_HALF] <= '0;
      end else if (load) begin
        held[h*XCV_HALF +: XCV_HALF] <= din[h*XCV_HALF +: XCV_HALF];
      end
    end
  end

endmodule : xcv_dir

//--- xcv_top_monitor.sv
// Concurrent checks on the transceiver top ports, bound to the top module.
`timescale 1ns/1ps
module xcv_top_monitor
  import xcv_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [XCV_AW-1:0] paddr,
  input wire logic [XCV_DW-1:0] pwdata,
  input wire logic [XCV_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Pins
  input wire logic [XCV_W-1:0]  a_in,
  input wire logic [XCV_W-1:0]  a_out,
  input wire logic [XCV_W-1:0]  a_oe_n,
  input wire logic [XCV_W-1:0]  b_in,
  input wire logic [XCV_W-1:0]  b_out,
  input wire logic [XCV_W-1:0]  b_oe_n,
  input wire xcv_dir_ctl_s      fwd_ctl,
  input wire xcv_dir_ctl_s      rev_ctl,
  input wire logic              tck,
  input wire logic              test_logic_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Shadow of the test mode bit, and a count of cycles spent in normal mode.
  logic       mode_q;
  logic [2:0] nm_q;
  wire        ctrl_wr = psel & penable & pready & pwrite & (paddr == OFS_CTRL);
  wire        norm    = (nm_q >= 3'h4);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) mode_q <= 1'b0;
    else if (test_logic_reset) mode_q <= 1'b0;
    else if (ctrl_wr) mode_q <= pwdata[CTRL_TEST_BIT];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) nm_q <= 3'h0;
    else if (mode_q) nm_q <= 3'h0;
    else if (nm_q != 3'h7) nm_q <= nm_q + 3'h1;
  end

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_fwd_hold0;
    !fwd_ctl.le[0] && !$rose(fwd_ctl.clk[0]);
  endsequence
  sequence s_fwd_rise1;
    !fwd_ctl.le[1] && $rose(fwd_ctl.clk[1]);
  endsequence

  chk_ready_next: assert property (s_access |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_unmapped_err: assert property (pready && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > OFS_REV_HELD)) else $error("pslverr wrong");
  chk_oe_follow: assert property (norm |->
    b_oe_n == {{XCV_HALF{$past(fwd_ctl.oe_n[1])}}, {XCV_HALF{$past(fwd_ctl.oe_n[0])}}} &&
    a_oe_n == {{XCV_HALF{$past(rev_ctl.oe_n[1])}}, {XCV_HALF{$past(rev_ctl.oe_n[0])}}})
    else $error("output enable does not follow control");
  chk_fwd_hold: assert property (s_fwd_hold0 |-> ##2 (!norm || $stable(b_out[8:0])))
    else $error("held B output changed");
  chk_fwd_capture: assert property (s_fwd_rise1 |-> ##2
    (!norm || b_out[17:9] == $past(a_in[17:9], 2))) else $error("clocked capture wrong");
  chk_fwd_transp: assert property (fwd_ctl.le[0] |-> ##2
    (!norm || b_out[8:0] == $past(a_in[8:0], 2))) else $error("B not following A");
  chk_rev_transp: assert property (rev_ctl.le[0] |-> ##2
    (!norm || a_out[8:0] == $past(b_in[8:0], 2))) else $error("A not following B");
  chk_test_drive: assert property (mode_q && $past(mode_q) |-> a_out == b_out)
    else $error("test mode pins differ");
endmodule : xcv_top_monitor

bind xcv_top xcv_top_monitor xcv_top_monitor_i (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .a_in(a_in), .a_out(a_out), .a_oe_n(a_oe_n),
  .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n), .fwd_ctl(fwd_ctl), .rev_ctl(rev_ctl),
  .tck(tck), .test_logic_reset(test_logic_reset));

//--- xcv_bus_model.sv
// Far-side bus logic on both ports: resolves each pin from the two drivers.
`timescale 1ns/1ps
module xcv_bus_model
  import xcv_pkg::*;
(
  // Design drive
  input  wire logic [XCV_W-1:0] a_out,
  input  wire logic [XCV_W-1:0] a_oe_n,
  input  wire logic [XCV_W-1:0] b_out,
  input  wire logic [XCV_W-1:0] b_oe_n,
  // Far-side drive
  input  wire logic [XCV_W-1:0] a_drv,
  input  wire logic [XCV_W-1:0] b_drv,
  // Pin levels
  output logic      [XCV_W-1:0] a_pin,
  output logic      [XCV_W-1:0] b_pin
);
  // The far side drives only the pins the design has released.
  assign a_pin = (a_out & ~a_oe_n) | (a_drv & a_oe_n);
  assign b_pin = (b_out & ~b_oe_n) | (b_drv & b_oe_n);
endmodule : xcv_bus_model

//--- xcv_top_tb.sv
// Self-checking testbench for the transceiver top.
`timescale 1ns/1ps
module xcv_top_tb import xcv_pkg::*;;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, tck = 0, test_logic_reset = 0;
  logic [XCV_AW-1:0] paddr = '0;
  logic [XCV_DW-1:0] pwdata = '0, prdata, rd;
  logic              pready, pslverr, er;
  logic [XCV_W-1:0]  a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, a_drv = '0, b_drv = '0;
  xcv_dir_ctl_s      fwd_ctl = '{2'b11, 2'b00, 2'b00}, rev_ctl = '{2'b11, 2'b00, 2'b00};
  int                err_total = 0, cmp_count = 0;

  always #12.5 mclk = ~mclk;

  xcv_top xcv_top_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .a_in(a_in), .a_out(a_out), .a_oe_n(a_oe_n), .b_in(b_in),
    .b_out(b_out), .b_oe_n(b_oe_n), .fwd_ctl(fwd_ctl), .rev_ctl(rev_ctl), .tck(tck),
    .test_logic_reset(test_logic_reset));
  xcv_bus_model xcv_bus_model_i (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
    .b_oe_n(b_oe_n), .a_drv(a_drv), .b_drv(b_drv), .a_pin(a_in), .b_pin(b_in));

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk_reg(input string nm, input logic [XCV_DW-1:0] e, input logic [XCV_DW-1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input logic [XCV_W-1:0] e, input logic [XCV_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin

  // One APB transfer; read data and error are taken at the edge that sees pready.
  // The wait has no limit of its own; only the watchdog ends a hung transfer.
  task automatic apb(input logic wr, input logic [XCV_AW-1:0] ad, input logic [XCV_DW-1:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [XCV_AW-1:0] ad, input logic [XCV_DW-1:0] e, input string nm);
    apb(1'b0, ad, '0);
    chk_reg(nm, e, rd);
  endtask : rdchk

  task automatic step(input int c);
    repeat (c) @(posedge mclk);
  endtask : step

  // One test clock rise, held high for three cycles so only one step may occur.
  task automatic tck_step;
    @(posedge mclk) tck <= 1'b1;
    step(3);
    tck <= 1'b0;
    step(2);
  endtask : tck_step

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    close_out();
  end

  initial begin
    step(4);
    nrst <= 1'b1;
    rdchk(OFS_CTRL, 32'h0, "ctrl_rst");
    rdchk(OFS_PATTERN, 32'h1, "pattern_rst");
    rdchk(OFS_SIG, 32'h0, "sig_rst");
    chk_pin("b_oe_n_rst", 18'h3FFFF, b_oe_n);
    $display("test reset done");
    @(posedge mclk) fwd_ctl <= '{2'b00, 2'b11, 2'b00};
    a_drv <= 18'h2A5C3;
    step(3);
    chk_pin("b_out_transp", 18'h2A5C3, b_out);
    chk_pin("b_oe_n_on", 18'h0, b_oe_n);
    rdchk(OFS_FWD_HELD, 32'h2A5C3, "fwd_held");
    $display("test transparent done");
    @(posedge mclk) fwd_ctl.le <= 2'b00;
    a_drv <= 18'h15A3C;
    step(4);
    chk_pin("b_out_held", 18'h2A5C3, b_out);
    @(posedge mclk) fwd_ctl.clk <= 2'b10;
    step(2);
    fwd_ctl.clk <= 2'b00;
    step(3);
    chk_pin("b_out_clocked", 18'h15BC3, b_out);
    @(posedge mclk) fwd_ctl.oe_n <= 2'b01;
    step(3);
    chk_pin("b_oe_n_half", 18'h001FF, b_oe_n);
    fwd_ctl.oe_n <= 2'b11;
    $display("test latched and clocked done");
    @(posedge mclk) rev_ctl <= '{2'b00, 2'b11, 2'b00};
    b_drv <= 18'h3C0F1;
    step(4);
    chk_pin("a_out_rev", 18'h3C0F1, a_out);
    chk_pin("a_oe_n_rev", 18'h0, a_oe_n);
    rev_ctl <= '{2'b11, 2'b00, 2'b00};
    step(3);
    rdchk(OFS_REV_HELD, 32'h3C0F1, "rev_held");
    $display("test reverse done");
    apb(1'b1, OFS_STATUS, 32'hFF);
    rdchk(OFS_STATUS, 32'h0, "status_ro");
    apb(1'b0, 8'h40, '0);
    chk_reg("unmapped_err", 32'h1, {31'h0, er});
    chk_reg("unmapped_data", 32'h0, rd);
    $display("test bus done");
    apb(1'b1, OFS_CTRL, 32'h2);
    tck_step();
    rdchk(OFS_SAMPLE_A, 32'h15A3C, "sample_a");
    rdchk(OFS_SAMPLE_B, 32'h3C0F1, "sample_b");
    rdchk(OFS_SAMPLE_CTL, 32'hC30, "sample_ctl");
    rdchk(OFS_FWD_HELD, 32'h15BC3, "held_kept");
    apb(1'b1, OFS_SIG, 32'h20000);
    apb(1'b1, OFS_CTRL, 32'h5);
    tck_step();
    rdchk(OFS_SIG, 32'h1 ^ 32'h15A3C ^ 32'h3C0F1, "signature");
    $display("test sample and signature done");
    apb(1'b1, OFS_PATTERN, 32'h00401);
    apb(1'b1, OFS_CTRL, 32'h1F);
    tck_step();
    rdchk(OFS_PATTERN, 32'h00803, "pattern_step");
    chk_pin("a_out_test", 18'h00803, a_out);
    chk_pin("b_out_test", 18'h00803, b_out);
    chk_pin("a_oe_n_test", 18'h0, a_oe_n);
    rdchk(OFS_STATUS, 32'h1, "status_test");
    $display("test pattern done");
    @(posedge mclk) test_logic_reset <= 1'b1;
    step(3);
    rdchk(OFS_CTRL, 32'h0, "ctrl_tlr");
    rdchk(OFS_PATTERN, 32'h1, "pattern_tlr");
    rdchk(OFS_STATUS, 32'h2, "status_tlr");
    test_logic_reset <= 1'b0;
    step(4);
    chk_pin("a_oe_n_tlr", 18'h3FFFF, a_oe_n);
    $display("test logic reset done");
    close_out();
  end
endmodule : xcv_top_tb
